/* logic/adcsf_params.svh */
// How it works
// - Conversion end with ready set raises overrun
// - Status read clears general overrun unless re-set
// - Other channel disable never blocks ready flag
// - Result read during conversion end still flags overrun
// - Other channel disable during a repeat end still sets both overrun flags
// - Status read clears stale channel overruns
// - Channel disabled mid-conversion raises no end flag
// - Result read clears only its channel flag
// - Low power takes effect after next conversion
// - Only last-result read clears ready flag
`ifndef ADCSF_PARAMS_SVH
`define ADCSF_PARAMS_SVH
// Register byte offsets
`define ADCSF_CTRL_OFS      8'h00
`define ADCSF_MODE_OFS      8'h04
`define ADCSF_CHEN_OFS      8'h08
`define ADCSF_STAT_OFS      8'h10
`define ADCSF_LAST_OFS      8'h14
`define ADCSF_IST_OFS       8'h18
`define ADCSF_IMASK_OFS     8'h1C
`define ADCSF_RES_BASE      8'h20
`define ADCSF_RES_END       8'h3C
// Field positions
`define ADCSF_CTRL_START    0
`define ADCSF_MODE_LP       0
`define ADCSF_STAT_OVR_LSB  8
`define ADCSF_STAT_DATA_READY_FLAG     16
`define ADCSF_STAT_GOVR     17
`define ADCSF_STAT_SLEEP    18
`define ADCSF_LAST_CH_LSB   12
`define ADCSF_IRQ_DATA_READY_FLAG      0
`define ADCSF_IRQ_GOVR      1
`define ADCSF_IRQ_OVR       2
// Reset values
`define ADCSF_CHEN_RST      8'h00
`define ADCSF_IMASK_RST     3'h0
// Bus responses
`define ADCSF_RESP_OKAY     2'h0
`define ADCSF_RESP_SLVERR   2'h2
`endif

/* logic/adcsf_pkg.sv */
package adcsf_pkg;
	localparam int ADCSF_NCH = 8;   // Channel count
	localparam int ADCSF_CHW = 3;   // Channel index width
	localparam int ADCSF_DW  = 10;  // Result width
	// End-of-conversion report from the core
	typedef struct packed {
		logic                 done;
		logic [ADCSF_CHW-1:0] ch;
		logic [ADCSF_DW-1:0]  data;
	} adcsf_conv_s;
	// Status flags kept by the block
	typedef struct packed {
		logic                 govr;
		logic                 data_ready_flag;
		logic [ADCSF_NCH-1:0] ovr;
		logic [ADCSF_NCH-1:0] eoc;
	} adcsf_flags_s;
endpackage

/* logic/adcsf_top.sv */
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "adcsf_params.svh"
module adcsf_top
	import adcsf_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire adcsf_conv_s conv_in,
	output logic             conv_start,
	output logic             core_sleep,
	output logic             irq
);
	// Bus handshake state
	logic               bvalid_ff;
	logic [1:0]         bresp_ff;
	logic               rvalid_ff;
	logic [1:0]         rresp_ff;
	logic [31:0]        rdata_ff;
	// Software-visible control
	logic [ADCSF_NCH-1:0] chen_ff;
	logic [ADCSF_NCH-1:0] nxt_chen;
	logic                 lp_ff;
	logic [2:0]           imask_ff;
	logic [2:0]           ist_ff;
	// Core tracking
	logic                 start_ff;
	logic                 busy_ff;
	logic [ADCSF_NCH-1:0] dis_run_ff;  // Disabled while converting
	logic                 sleep_ff;
	// Flags and results
	adcsf_flags_s         flg_ff;
	adcsf_flags_s         nxt_flg;
	logic [ADCSF_DW-1:0]  res_mem [ADCSF_NCH];
	logic [ADCSF_DW-1:0]  last_data_ff;
	logic [ADCSF_CHW-1:0] last_ch_ff;
	// Decoded events
	logic                 wr_fire;
	logic                 rd_fire;
	logic                 rd_stat;
	logic                 rd_last;
	logic                 rd_cdr;
	logic [ADCSF_NCH-1:0] cdr_mask;    // Channel whose result is read
	logic                 ch_ok;
	logic                 evt;         // Accepted end of conversion
	logic [ADCSF_NCH-1:0] evt_mask;
	logic                 govr_set;
	logic [ADCSF_NCH-1:0] ovr_set;
	logic [31:0]          rd_mux;
	logic                 rd_hit;

	// True when the address falls in the result window
	function automatic logic res_hit(input logic [7:0] a);
		res_hit = (a >= `ADCSF_RES_BASE) && (a <= `ADCSF_RES_END) && (a[1:0] == 2'b00);
	endfunction

	// Channel index from a result-window address
	function automatic logic [ADCSF_CHW-1:0] res_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - `ADCSF_RES_BASE;
		res_idx = d[ADCSF_CHW+1:2];
	endfunction

	// Write and read acceptance; one of each in flight at most
	assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
	assign s_axi_wready  = s_axi_awready;
	assign wr_fire       = s_axi_awready;
	assign s_axi_arready = ~rvalid_ff;
	assign rd_fire       = s_axi_arvalid & s_axi_arready;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;

	// Read side effects, taken on the accept edge
	assign rd_stat  = rd_fire & (s_axi_araddr == `ADCSF_STAT_OFS);
	assign rd_last  = rd_fire & (s_axi_araddr == `ADCSF_LAST_OFS);
	assign rd_cdr   = rd_fire & res_hit(s_axi_araddr);
	assign cdr_mask = rd_cdr ? (ADCSF_NCH'(1) << res_idx(s_axi_araddr)) : '0;

	// Enable register after this cycle's write
	always_comb begin
		nxt_chen = chen_ff;
		if (wr_fire && s_axi_awaddr == `ADCSF_CHEN_OFS && s_axi_wstrb[0]) begin
			nxt_chen = s_axi_wdata[ADCSF_NCH-1:0];
		end
	end

	// A disable in the same cycle as the end counts as disabled
	// Sampling both sides of the enable write closes the same-cycle gap
	assign ch_ok    = chen_ff[conv_in.ch] & nxt_chen[conv_in.ch] & ~dis_run_ff[conv_in.ch];
	assign evt      = conv_in.done & ch_ok;
	assign evt_mask = evt ? (ADCSF_NCH'(1) << conv_in.ch) : '0;
	assign ovr_set  = evt_mask & flg_ff.eoc;
	assign govr_set = evt & flg_ff.data_ready_flag;

	// Next flag values; every set wins over a clear in the same cycle
	always_comb begin
		nxt_flg = flg_ff;
		// End flags: a read of a result clears only its own channel
		nxt_flg.eoc = flg_ff.eoc & ~cdr_mask;
		if (rd_last) begin
			nxt_flg.eoc[last_ch_ff] = 1'b0;
		end
		nxt_flg.eoc = nxt_flg.eoc | evt_mask;
		// Channel overruns: status read clears, new overrun sets
		nxt_flg.ovr = (rd_stat ? '0 : flg_ff.ovr) | ovr_set;
		// Ready: only the last-result read clears it
		nxt_flg.data_ready_flag = (flg_ff.data_ready_flag & ~rd_last) | evt;
		// General overrun: status read clears it unless a new overrun sets it
		nxt_flg.govr = (flg_ff.govr & ~rd_stat) | govr_set;
	end

	// Flag storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flg_ff <= '0;
		end else begin
			flg_ff <= nxt_flg;
		end
	end

	// Result storage; the array has no reset to stay a plain memory
	always_ff @(posedge aclk) begin
		if (evt) begin
			res_mem[conv_in.ch] <= conv_in.data;
		end
	end

	// Last result and its channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_data_ff <= '0;
			last_ch_ff   <= '0;
		end else if (evt) begin
			last_data_ff <= conv_in.data;
			last_ch_ff   <= conv_in.ch;
		end
	end

	// Control registers written by software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chen_ff  <= `ADCSF_CHEN_RST;
			lp_ff    <= 1'b0;
			imask_ff <= `ADCSF_IMASK_RST;
		end else begin
			chen_ff <= nxt_chen;
			if (wr_fire && s_axi_wstrb[0]) begin
				// Mode and mask only; enable handled above
				if (s_axi_awaddr == `ADCSF_MODE_OFS) begin
					lp_ff <= s_axi_wdata[`ADCSF_MODE_LP];
				end
				if (s_axi_awaddr == `ADCSF_IMASK_OFS) begin
					imask_ff <= s_axi_wdata[2:0];
				end
			end
		end
	end

	// Start pulse to the core, one cycle per control write with the start bit set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_ff <= 1'b0;
		end else begin
			start_ff <= wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `ADCSF_CTRL_OFS
				&& s_axi_wdata[`ADCSF_CTRL_START];
		end
	end
	assign conv_start = start_ff;

	// Busy from start until the core reports an end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_ff <= 1'b0;
		end else if (start_ff) begin
			busy_ff <= 1'b1;
		end else if (conv_in.done) begin
			busy_ff <= 1'b0;
		end
	end

	// Remember channels switched off during a running conversion
	// A re-enable does not undo the mark; that run's result is dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dis_run_ff <= '0;
		end else if (start_ff) begin
			dis_run_ff <= '0;
		end else if (busy_ff) begin
			dis_run_ff <= dis_run_ff | (chen_ff & ~nxt_chen);
		end
	end

	// Low power is entered at a conversion end, so an idle write waits
	// Limitation: an end on a disabled channel still puts the core to sleep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_ff <= 1'b0;
		end else if (!lp_ff || start_ff) begin
			sleep_ff <= 1'b0;
		end else if (conv_in.done) begin
			sleep_ff <= 1'b1;
		end
	end
	assign core_sleep = sleep_ff;

	// Interrupt status, write one to clear, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ist_ff <= '0;
		end else begin
			ist_ff <= (ist_ff & ~((wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `ADCSF_IST_OFS)
				? s_axi_wdata[2:0] : 3'h0)) | {(|ovr_set), govr_set, evt};
		end
	end
	assign irq = |(ist_ff & imask_ff);

	// Read data selection
	// Returns the value before this cycle's read side effects apply
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		if (res_hit(s_axi_araddr)) begin
			rd_mux[ADCSF_DW-1:0] = res_mem[res_idx(s_axi_araddr)];
		end else begin
			unique case (s_axi_araddr)
				`ADCSF_CTRL_OFS:  rd_mux = '0;
				`ADCSF_MODE_OFS:  rd_mux[`ADCSF_MODE_LP] = lp_ff;
				`ADCSF_CHEN_OFS:  rd_mux[ADCSF_NCH-1:0] = chen_ff;
				`ADCSF_STAT_OFS: begin
					rd_mux[ADCSF_NCH-1:0] = flg_ff.eoc;
					rd_mux[`ADCSF_STAT_OVR_LSB +: ADCSF_NCH] = flg_ff.ovr;
					rd_mux[`ADCSF_STAT_DATA_READY_FLAG]  = flg_ff.data_ready_flag;
					rd_mux[`ADCSF_STAT_GOVR]  = flg_ff.govr;
					rd_mux[`ADCSF_STAT_SLEEP] = sleep_ff;
				end
				`ADCSF_LAST_OFS: begin
					rd_mux[ADCSF_DW-1:0] = last_data_ff;
					rd_mux[`ADCSF_LAST_CH_LSB +: ADCSF_CHW] = last_ch_ff;
				end
				`ADCSF_IST_OFS:   rd_mux[2:0] = ist_ff;
				`ADCSF_IMASK_OFS: rd_mux[2:0] = imask_ff;
				default:          rd_hit = 1'b0;
			endcase
		end
	end

	// Read answer one cycle after accept, held until taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= `ADCSF_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_mux;
			rresp_ff  <= rd_hit ? `ADCSF_RESP_OKAY : `ADCSF_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Write answer one cycle after accept; unmapped gets an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `ADCSF_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (s_axi_awaddr inside {`ADCSF_CTRL_OFS, `ADCSF_MODE_OFS,
				`ADCSF_CHEN_OFS, `ADCSF_IST_OFS, `ADCSF_IMASK_OFS})
				? `ADCSF_RESP_OKAY : `ADCSF_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Checks on the flag logic
	AST_GOVR_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		evt && flg_ff.data_ready_flag |=> flg_ff.govr)
		else $error("general overrun missed");
	AST_GOVR_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_stat && !(evt && flg_ff.data_ready_flag) |=> !flg_ff.govr)
		else $error("general overrun not cleared by status read");
	AST_DATA_READY_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		evt && (nxt_chen != chen_ff) |=> flg_ff.data_ready_flag)
		else $error("ready lost during disable");
	AST_GOVR_CDR: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_cdr && evt && flg_ff.data_ready_flag && !flg_ff.govr ##1 1'b1 |-> flg_ff.govr)
		else $error("overrun lost on result read");
	AST_BOTH_OVR: assert property (@(posedge aclk) disable iff (!aresetn)
		evt && flg_ff.data_ready_flag && |(evt_mask & flg_ff.eoc) |=> flg_ff.govr && (|flg_ff.ovr))
		else $error("overrun pair not set");
	AST_OVR_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_stat && ovr_set == '0 |=> flg_ff.ovr == '0)
		else $error("channel overrun survives status read");
	AST_NO_EOC: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_in.done && (dis_run_ff[conv_in.ch] || !nxt_chen[conv_in.ch])
		&& !flg_ff.eoc[conv_in.ch] |=> !flg_ff.eoc[$past(conv_in.ch)])
		else $error("end flag raised on disabled channel");
	AST_CDR_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_cdr && !rd_last |=> (flg_ff.eoc & ~$past(evt_mask)) ==
		($past(flg_ff.eoc) & ~$past(cdr_mask) & ~$past(evt_mask)))
		else $error("result read cleared a foreign end flag");
	AST_SLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(sleep_ff) |-> $past(conv_in.done) && $past(lp_ff))
		else $error("sleep entered without conversion end");
	AST_DATA_READY_FLAG_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		flg_ff.data_ready_flag && !rd_last |=> flg_ff.data_ready_flag)
		else $error("ready cleared without last-result read");
	AST_EOC_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		evt |=> flg_ff.eoc[last_ch_ff] && flg_ff.data_ready_flag)
		else $error("end of conversion not recorded");

	// Further flag checks
	AST_OVR_CH: assert property (@(posedge aclk) disable iff (!aresetn)
		evt && (evt_mask & flg_ff.eoc) != '0 |=> (flg_ff.ovr & $past(evt_mask)) != '0)
		else $error("channel overrun missed");
	AST_SLEEP_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
		lp_ff && !sleep_ff && !conv_in.done |=> !sleep_ff)
		else $error("sleep entered while idle");

	// Bus answers come exactly one cycle after the accept edge
	AST_B_ANS: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid)
		else $error("write answer late");
	AST_R_ANS: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_fire |=> s_axi_rvalid)
		else $error("read answer late");
endmodule

/* verif/adcsf_core_model.sv */
`timescale 1ns/1ps
module adcsf_core_model
	import adcsf_pkg::*;
#(
	parameter int CONV_CYC = 8
)
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 conv_start,
	input  wire logic                 req,
	input  wire logic [ADCSF_CHW-1:0] req_ch,
	input  wire logic [ADCSF_DW-1:0]  req_data,
	input  wire logic [ADCSF_CHW-1:0] seq_ch,
	output adcsf_conv_s               conv_in
);
	int          cnt_ff;  // Cycles left in a started conversion
	logic [13:0] idle_ff; // Filler that changes every cycle between results

	// Conversion timer; filler toggles so a stale value never looks valid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff  <= 0;
			idle_ff <= 14'h0155;
		end else begin
			idle_ff <= ~idle_ff;
			if (conv_start) begin
				cnt_ff <= CONV_CYC;
			end else if (cnt_ff != 0) begin
				cnt_ff <= cnt_ff - 1;
			end
		end
	end

	// Bench pulse wins, else the end of a started conversion
	always_comb begin
		conv_in = {1'b0, idle_ff[12:0]};
		if (req) begin
			conv_in = {1'b1, req_ch, req_data};
		end else if (cnt_ff == 1) begin
			conv_in = {1'b1, seq_ch, idle_ff[9:0]};
		end
	end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
`include "adcsf_params.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench
	import adcsf_pkg::*;
;
	logic        aclk = 1'b0;    // 50 MHz system clock
	logic        aresetn = 1'b0; // Held low for ten cycles
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hF; // Full words only
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [31:0] s_axi_rdata, rv;
	logic        conv_start, core_sleep, irq;
	adcsf_conv_s conv_in;
	logic        req = 1'b0;      // Converter pulse request
	logic [2:0]  req_ch = 3'h0, seq_ch = 3'h0;
	logic [9:0]  req_data = 10'h000;
	int          failures = 0, comparisons = 0;

	always #10 aclk = ~aclk;

	adcsf_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_in,
		.conv_start, .core_sleep, .irq);
	adcsf_core_model #(.CONV_CYC(8)) core (.aclk, .aresetn, .conv_start, .req,
		.req_ch, .req_data, .seq_ch, .conv_in);

	// Write one word; any pending pulse ends at the accept edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		req <= 1'b0;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Read one word; side effects land at the accept edge with any pulse
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		req <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Arm a conversion end for the next edge
	task automatic ev(input logic [2:0] c, input logic [9:0] d);
		req <= 1'b1;
		req_ch <= c;
		req_data <= d;
	endtask

	// Lone conversion end, then one quiet edge so the next pulse is distinct
	task automatic ev1(input logic [2:0] c, input logic [9:0] d);
		ev(c, d);
		@(posedge aclk);
		req <= 1'b0;
		@(posedge aclk);
	endtask

	// Status read against an expected word
	task automatic st(input logic [31:0] e);
		rd(`ADCSF_STAT_OFS);
		`CHK(rv, e)
	endtask

	// Ready, general overrun and per-channel clears
	task automatic t_flags();
		ev1(3'h2, 10'h12A);
		rd(8'h28);
		`CHK(rv, 32'h0000_012A)
		ev1(3'h7, 10'h0C3);
		ev1(3'h5, 10'h200);
		st(32'h0003_00A0);
		ev(3'h7, 10'h3C3);
		rd(8'h28);
		st(32'h0003_80A0);
		ev(3'h2, 10'h2F1);
		rd(8'h34);
		st(32'h0003_0084);
		st(32'h0001_0084);
		rd(`ADCSF_LAST_OFS);
		`CHK(rv, 32'h0000_22F1)
		st(32'h0000_0080);
		rd(8'h3C);
	endtask

	// Stale channel overrun and general overrun under a coincident status read
	task automatic t_ovr();
		ev1(3'h3, 10'h011);
		ev1(3'h3, 10'h022);
		rd(8'h2C);
		ev(3'h3, 10'h033);
		st(32'h0003_0800);
		rd(`ADCSF_LAST_OFS);
		`CHK(rv, 32'h0000_3033)
		ev(3'h4, 10'h044);
		st(32'h0002_0000);
		st(32'h0001_0010);
		rd(`ADCSF_LAST_OFS);
	endtask

	// Disabling another channel as a conversion ends
	task automatic t_dis();
		ev(3'h0, 10'h0AA);
		wr(`ADCSF_CHEN_OFS, 32'h0000_00BF);
		st(32'h0001_0001);
		ev(3'h0, 10'h0BB);
		wr(`ADCSF_CHEN_OFS, 32'h0000_003F);
		st(32'h0003_0101);
		rd(`ADCSF_LAST_OFS);
		`CHK(rv, 32'h0000_00BB)
	endtask

	// Disable mid-conversion, then deferred low power
	task automatic t_sleep();
		wr(`ADCSF_CHEN_OFS, 32'h0000_00FF);
		seq_ch <= 3'h7;
		wr(`ADCSF_CTRL_OFS, 32'h0000_0001);
		wr(`ADCSF_CHEN_OFS, 32'h0000_007F);
		wr(`ADCSF_CHEN_OFS, 32'h0000_00FF);
		repeat (12) @(posedge aclk);
		st(32'h0000_0000);
		wr(`ADCSF_MODE_OFS, 32'h0000_0001);
		repeat (12) @(posedge aclk);
		`CHK(core_sleep, 1'b0)
		seq_ch <= 3'h0;
		wr(`ADCSF_CTRL_OFS, 32'h0000_0001);
		`CHK(conv_start, 1'b1)
		repeat (12) @(posedge aclk);
		`CHK(core_sleep, 1'b1)
		st(32'h0005_0001);
	endtask

	// Interrupt mask and clear, refused accesses
	task automatic t_irq();
		rd(`ADCSF_IST_OFS);
		`CHK(rv, 32'h0000_0007)
		wr(`ADCSF_IMASK_OFS, 32'h0000_0000);
		`CHK(irq, 1'b0)
		wr(`ADCSF_IMASK_OFS, 32'h0000_0007);
		`CHK(irq, 1'b1)
		wr(`ADCSF_IST_OFS, 32'h0000_0007);
		`CHK(irq, 1'b0)
		rd(8'h40);
		`CHK({rr, rv}, {`ADCSF_RESP_SLVERR, 32'h0000_0000})
		wr(`ADCSF_STAT_OFS, 32'h0000_0007);
		`CHK(rr, `ADCSF_RESP_SLVERR)
	endtask

	// Verdict and end of run
	task automatic summarize();
		if (failures == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Hang guard, far beyond the roughly 140 cycles the tests need
	initial begin
		repeat (5000) @(posedge aclk);
		failures++;
		summarize();
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`ADCSF_IMASK_OFS);
		`CHK(rv, 32'h0000_0000)
		st(32'h0000_0000);
		wr(`ADCSF_CHEN_OFS, 32'h0000_00FF);
		wr(`ADCSF_IMASK_OFS, 32'h0000_0007);
		`CHK(rr, `ADCSF_RESP_OKAY)
		t_flags();
		t_ovr();
		t_dis();
		t_sleep();
		t_irq();
		summarize();
	end
endmodule
